// ### rtl/rfsr_regs.sv
// rfsr_regs: apb register bank for radio status, frame fsm control,
// debug pin routing and delayed analog regulator power-on.
// assumes live radio inputs synchronous to pclk and a single apb master.
//
// Contract
// RULE1: read-only receive buffer byte count, reset zero
// RULE2: abort bit makes receive strobe abort reception
// RULE3: interrupted flag set by strobe, cleared next strobe
// RULE4: bit3 low gives automatic receive after send
// RULE5: bit2 high disables twelve symbol receive timeout
// RULE6: bit1 ored with filter pending to modulator
// RULE7: bit0 low rejects acknowledge frames
// RULE8: fixed identity and revision read-only registers
// RULE9: status bit4 shows transmission in progress
// RULE10: status bit3 shows buffer not empty
// RULE11: status bit2 shows count above threshold
// RULE12: status bits1,0 show delimiter and channel clear
// RULE13: four status signals routable to debug pins
// RULE14: powerdown bit set disables, clear starts delay
// RULE15: delay expiry sets regulator ready irq flag
// RULE16: pending bit lets software poll power-on
// RULE17: digital regulator off in deep modes, retention
// RULE18: seven-bit threshold level, reset 0x40
// RULE19: pin enable gates output, polarity xors signal
// RULE20: read-only registers ignore writes, reads harmless
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps

module rfsr_regs
  import rfsr_pkg::*;
#(
  parameter int         RX_TO_CYC = RX_TO_CYCLES,
  parameter int         REG_UNIT  = REG_UNIT_CYCLES,
  parameter logic [7:0] REVISION  = REVISION_DEFAULT,
  parameter logic [7:0] IDENTITY  = IDENTITY_DEFAULT
) (
  input  logic              pclk,
  input  logic              presetn,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [ADDR_W-1:0] paddr,
  input  logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  rfsr_link_t        link,
  input  logic [1:0]        pm_mode,
  output rfsr_ctrl_t        ctrl,
  output logic [3:0]        dbg_out,
  output logic [3:0]        dbg_oe
);

  // whole module state
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic [6:0]        thr;
    logic [6:0]        cfg_b;
    logic [6:0]        cfg_c;
    logic [5:0]        cfg_d;
    logic [5:0]        fsm;
    logic              pwr_pd;
    logic              pwr_pending;
    logic [7:0]        pwr_dly;
    logic              irq_flag;
    logic [15:0]       dly_cnt;
    logic [15:0]       to_cnt;
    logic              to_run;
    rfsr_ctrl_t        ctrl;
    logic [3:0]        dbg_out;
    logic [3:0]        dbg_oe;
  } rfsr_state_t;

  rfsr_state_t st;
  rfsr_state_t next_st;

  // index match on a word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // a register exists at this address
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_IO_CONFIG_A) | hit(a, IDX_IO_CONFIG_B) | hit(a, IDX_IO_CONFIG_C)
           | hit(a, IDX_IO_CONFIG_D) | hit(a, IDX_RX_BYTE_COUNT) | hit(a, IDX_FSM_TIMING)
           | hit(a, IDX_SILICON_REV) | hit(a, IDX_SILICON_ID) | hit(a, IDX_LIVE_STATUS)
           | hit(a, IDX_RADIO_POWER) | hit(a, IDX_POWER_DELAY) | hit(a, IDX_IRQ_FLAGS)
           | hit(a, IDX_STROBE);
  endfunction

  // live status decoding
  logic       buf_ne;
  logic       thr_flag;
  logic [7:0] status_byte;
  logic [3:0] dbg_sig;
  logic [3:0] dbg_pol;
  logic [3:0] dbg_en;

  // status bits from the live radio signals
  always_comb begin
    buf_ne      = (link.rx_count != 8'h00);                         // see RULE10
    thr_flag    = (link.rx_count > {1'b0, st.thr});                 // see RULE11
    status_byte = {3'h0, link.tx_active, buf_ne, thr_flag, link.sfd, link.cca}; // see RULE9 RULE12
    dbg_sig     = {link.cca, link.sfd, thr_flag, buf_ne};           // see RULE13
    dbg_pol     = {st.cfg_b[IO_POL], st.cfg_c[IO_POL], st.cfg_d[IO_THR_POL], st.cfg_d[IO_BUF_POL]};
    dbg_en      = {st.cfg_b[IO_OE] & (st.cfg_b[4:0] == 5'h00),
                   st.cfg_c[IO_OE] & (st.cfg_c[4:0] == 5'h00),
                   st.cfg_d[IO_THR_OE], st.cfg_d[IO_BUF_OE]};
  end

  // bus phases
  logic       acc_wait;
  logic       wr_now;
  logic [7:0] wb;
  logic       strobe;
  logic       intr_now;
  logic [7:0] rd_byte;

  // next-state logic for bus, registers and sequencing
  always_comb begin
    next_st  = st;
    acc_wait = psel & penable & ~st.pready;
    wr_now   = psel & penable & st.pready & pwrite & ~st.pslverr;
    wb       = pwdata[7:0];
    strobe   = 1'b0;
    intr_now = 1'b0;
    rd_byte  = 8'h00;

    // one-cycle pulses fall by default
    next_st.ctrl.rx_on      = 1'b0;
    next_st.ctrl.tx_on      = 1'b0;
    next_st.ctrl.rf_off     = 1'b0;
    next_st.ctrl.abort_rx   = 1'b0;
    next_st.ctrl.auto_rx    = 1'b0;
    next_st.ctrl.rx_timeout = 1'b0;

    // read data, side-effect free
    if (hit(paddr, IDX_IO_CONFIG_A)) rd_byte = {1'b0, st.thr};                 // see RULE18
    if (hit(paddr, IDX_IO_CONFIG_B)) rd_byte = {1'b0, st.cfg_b};
    if (hit(paddr, IDX_IO_CONFIG_C)) rd_byte = {1'b0, st.cfg_c};
    if (hit(paddr, IDX_IO_CONFIG_D)) rd_byte = {2'h0, st.cfg_d};
    if (hit(paddr, IDX_RX_BYTE_COUNT)) rd_byte = link.rx_count;               // see RULE1
    if (hit(paddr, IDX_FSM_TIMING)) rd_byte = {2'h0, st.fsm};
    if (hit(paddr, IDX_SILICON_REV)) rd_byte = REVISION;                      // see RULE8
    if (hit(paddr, IDX_SILICON_ID)) rd_byte = IDENTITY;                       // see RULE8
    if (hit(paddr, IDX_LIVE_STATUS)) rd_byte = status_byte;                   // see RULE20
    if (hit(paddr, IDX_RADIO_POWER)) rd_byte = {6'h0, st.pwr_pending, st.pwr_pd}; // see RULE16
    if (hit(paddr, IDX_POWER_DELAY)) rd_byte = st.pwr_dly;
    if (hit(paddr, IDX_IRQ_FLAGS)) rd_byte = {7'h0, st.irq_flag};

    // access phase: answer one cycle after penable rises
    if (acc_wait) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~mapped(paddr);
      next_st.prdata  = (~pwrite & mapped(paddr)) ? {24'h0, rd_byte} : '0;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // writes land on the edge that samples pready; read-only ones drop
    if (wr_now) begin
      if (hit(paddr, IDX_IO_CONFIG_A)) next_st.thr = wb[6:0];                 // see RULE18
      if (hit(paddr, IDX_IO_CONFIG_B)) next_st.cfg_b = wb[6:0];
      if (hit(paddr, IDX_IO_CONFIG_C)) next_st.cfg_c = wb[6:0];
      if (hit(paddr, IDX_IO_CONFIG_D)) next_st.cfg_d = wb[5:0];
      if (hit(paddr, IDX_FSM_TIMING)) begin                                   // see RULE20
        next_st.fsm = {wb[FSM_ABORT_RX], st.fsm[FSM_RX_INTR], wb[3:0]};
      end
      if (hit(paddr, IDX_POWER_DELAY)) next_st.pwr_dly = wb;
      if (hit(paddr, IDX_STROBE)) begin
        strobe = (wb == CMD_RX_ON) | (wb == CMD_TX_ON) | (wb == CMD_RF_OFF);
        next_st.ctrl.rx_on  = (wb == CMD_RX_ON);
        next_st.ctrl.tx_on  = (wb == CMD_TX_ON);
        next_st.ctrl.rf_off = (wb == CMD_RF_OFF);
      end
      if (hit(paddr, IDX_RADIO_POWER)) begin
        if (wb[PWR_PD]) begin                                                 // see RULE14
          next_st.pwr_pd      = 1'b1;
          next_st.pwr_pending = 1'b1;
          next_st.dly_cnt     = 16'h0000;
        end else if (st.pwr_pd) begin                                         // see RULE14
          next_st.pwr_pd      = 1'b0;
          next_st.pwr_pending = 1'b1;
          next_st.dly_cnt     = 16'(st.pwr_dly * REG_UNIT);
        end
      end
      if (hit(paddr, IDX_IRQ_FLAGS) & wb[IRQ_REG_RDY]) next_st.irq_flag = 1'b0;
    end

    // strobe handling: abort and interrupted flag
    if (strobe) begin
      intr_now = link.rx_busy & ((wb != CMD_RX_ON) | st.fsm[FSM_ABORT_RX]);   // see RULE2
      next_st.fsm[FSM_RX_INTR] = intr_now;                                    // see RULE3
      next_st.ctrl.abort_rx    = intr_now;                                    // see RULE2
    end

    // automatic receive after any transmission
    if (link.tx_done & ~st.fsm[FSM_NO_AUTO_RX]) next_st.ctrl.auto_rx = 1'b1; // see RULE4

    // post-reception timeout
    if (st.fsm[FSM_TO_DISABLE]) begin                                         // see RULE5
      next_st.to_run = 1'b0;
    end else if (link.rx_end) begin
      next_st.to_run = 1'b1;
      next_st.to_cnt = 16'(RX_TO_CYC - 1);
    end else if (st.to_run) begin
      if (st.to_cnt == 16'h0000) begin
        next_st.to_run          = 1'b0;
        next_st.ctrl.rx_timeout = 1'b1;
      end else begin
        next_st.to_cnt = st.to_cnt - 16'h0001;
      end
    end

    // regulator power-on delay; any write to a mapped register holds the count for one cycle,
    // so a power-down write or an irq clear never meets the expiry
    if (~st.pwr_pd & st.pwr_pending & ~wr_now) begin
      if (st.dly_cnt == 16'h0000) begin
        next_st.pwr_pending = 1'b0;
        next_st.irq_flag    = 1'b1;                                          // see RULE15
      end else begin
        next_st.dly_cnt = st.dly_cnt - 16'h0001;
      end
    end

    // level controls towards the radio core
    next_st.ctrl.pending_to_mod = st.fsm[FSM_PENDING_OR] | link.filter_pending; // see RULE6
    next_st.ctrl.accept_ack     = st.fsm[FSM_ACCEPT_ACK];                   // see RULE7
    next_st.ctrl.ana_reg_en     = ~next_st.pwr_pd & ~next_st.pwr_pending;   // see RULE14
    next_st.ctrl.dig_reg_en     = (pm_mode < 2'd2);                         // see RULE17

    // debug pin routing
    for (int i = 0; i < 4; i++) begin
      next_st.dbg_oe[i]  = dbg_en[i];                                        // see RULE19
      next_st.dbg_out[i] = dbg_en[i] & (dbg_sig[i] ^ dbg_pol[i]);           // see RULE19
    end
  end

  // state register; power modes never reset it, so contents are retained
  always_ff @(posedge pclk or negedge presetn) begin                         // see RULE17
    if (!presetn) begin
      st             <= '0;
      st.thr         <= THRESHOLD_RESET;
      st.fsm         <= FSM_RESET;
      st.pwr_pd      <= 1'b1;
      st.pwr_pending <= 1'b1;
      st.pwr_dly     <= POWER_DELAY_RESET;
      st.ctrl.accept_ack <= 1'b1;
      st.ctrl.dig_reg_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign ctrl    = st.ctrl;
  assign dbg_out = st.dbg_out;
  assign dbg_oe  = st.dbg_oe;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_req(logic [15:0] idx);
    psel & penable & ~pready & ~pwrite & hit(paddr, idx);
  endsequence

  sequence strobe_req(logic [7:0] cmd);
    psel & penable & pready & pwrite & hit(paddr, IDX_STROBE) & (pwdata[7:0] == cmd);
  endsequence

  count_read_a: assert property (rd_req(IDX_RX_BYTE_COUNT) |=>  // see RULE1
    prdata == {24'h0, $past(link.rx_count)})
    else $error("byte count read wrong");

  identity_read_a: assert property (rd_req(IDX_SILICON_ID) |=> // see RULE8
    prdata == {24'h0, IDENTITY})
    else $error("identity read wrong");

  revision_read_a: assert property (rd_req(IDX_SILICON_REV) |=> // see RULE8
    prdata == {24'h0, REVISION})
    else $error("revision read wrong");

  status_read_a: assert property (rd_req(IDX_LIVE_STATUS) |=> // see RULE12
    prdata == {24'h0, 3'h0, $past(link.tx_active), $past(link.rx_count != 8'h00),
               $past(link.rx_count > {1'b0, st.thr}), $past(link.sfd), $past(link.cca)})
    else $error("live status read wrong");

  rx_abort_a: assert property ( // see RULE2
    strobe_req(CMD_RX_ON) ##0 (link.rx_busy & st.fsm[FSM_ABORT_RX])
    |=> ctrl.abort_rx & st.fsm[FSM_RX_INTR])
    else $error("receive strobe did not abort");

  rx_keep_a: assert property ( // see RULE3
    strobe_req(CMD_RX_ON) ##0 ~st.fsm[FSM_ABORT_RX]
    |=> ~ctrl.abort_rx & ~st.fsm[FSM_RX_INTR])
    else $error("reception aborted while abort bit low");

  intr_clear_a: assert property ( // see RULE3
    strobe_req(CMD_TX_ON) ##0 ~link.rx_busy |=> ~st.fsm[FSM_RX_INTR])
    else $error("interrupted flag kept after a clean strobe");

  auto_rx_a: assert property ( // see RULE4
    (link.tx_done & ~st.fsm[FSM_NO_AUTO_RX]) |=> ctrl.auto_rx)
    else $error("no automatic receive after send");

  timeout_off_a: assert property ( // see RULE5
    st.fsm[FSM_TO_DISABLE] |=> ~st.to_run ##1 ~ctrl.rx_timeout)
    else $error("timeout ran while disabled");

  pending_or_a: assert property ( // see RULE6
    ##1 ctrl.pending_to_mod == $past(st.fsm[FSM_PENDING_OR] | link.filter_pending))
    else $error("pending bit not ored");

  accept_ack_a: assert property ( // see RULE7
    ##1 ctrl.accept_ack == $past(st.fsm[FSM_ACCEPT_ACK]))
    else $error("acknowledge control not followed");

  thr_pin_a: assert property (dbg_oe[1] |-> dbg_out[1] == // see RULE19
    ($past(link.rx_count > {1'b0, st.thr}) ^ $past(st.cfg_d[IO_THR_POL])))
    else $error("threshold pin wrong");

  pin_off_a: assert property (~dbg_oe[3] |-> ~dbg_out[3]) // see RULE13
    else $error("channel clear pin driven while disabled");

  reg_ready_a: assert property ( // see RULE15
    $fell(st.pwr_pending) & ~st.pwr_pd |-> st.irq_flag & ctrl.ana_reg_en)
    else $error("power-on expiry did not flag");

  reg_down_a: assert property (st.pwr_pd |-> st.pwr_pending & ~ctrl.ana_reg_en) // see RULE16
    else $error("regulator enabled while powered down");

  deep_mode_a: assert property ((pm_mode >= 2'd2) |=> ~ctrl.dig_reg_en) // see RULE17
    else $error("digital regulator on in deep mode");

  ro_write_a: assert property ( // see RULE20
    psel & penable & pready & pwrite & hit(paddr, IDX_SILICON_ID)
    |=> $stable(st.fsm) & $stable(st.thr))
    else $error("read-only write changed state");

endmodule

// ### rtl/rfsr_pkg.sv
// rfsr_pkg: register map, field layout, reset values and timing counts
// of the radio frame status register bank.
// assumes a 100 MHz APB clock and one aligned 32-bit word per register.
package rfsr_pkg;

  // apb geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_IO_CONFIG_A   = 16'hdf4f; // threshold level
  localparam logic [15:0] IDX_IO_CONFIG_B   = 16'hdf50; // channel clear pin
  localparam logic [15:0] IDX_IO_CONFIG_C   = 16'hdf51; // frame delimiter pin
  localparam logic [15:0] IDX_IO_CONFIG_D   = 16'hdf52; // buffer pins
  localparam logic [15:0] IDX_RX_BYTE_COUNT = 16'hdf53;
  localparam logic [15:0] IDX_FSM_TIMING    = 16'hdf54;
  localparam logic [15:0] IDX_SILICON_REV   = 16'hdf60;
  localparam logic [15:0] IDX_SILICON_ID    = 16'hdf61;
  localparam logic [15:0] IDX_LIVE_STATUS   = 16'hdf62;
  localparam logic [15:0] IDX_RADIO_POWER   = 16'hdf70;
  localparam logic [15:0] IDX_POWER_DELAY   = 16'hdf71;
  localparam logic [15:0] IDX_IRQ_FLAGS     = 16'hdf72;
  localparam logic [15:0] IDX_STROBE        = 16'hdf73;

  // frame fsm timing control fields
  localparam int FSM_ABORT_RX    = 5;
  localparam int FSM_RX_INTR     = 4;
  localparam int FSM_NO_AUTO_RX  = 3;
  localparam int FSM_TO_DISABLE  = 2;
  localparam int FSM_PENDING_OR  = 1;
  localparam int FSM_ACCEPT_ACK  = 0;
  localparam logic [5:0] FSM_RESET = 6'h21;

  // io config fields
  localparam int IO_OE       = 6;
  localparam int IO_POL      = 5;
  localparam int IO_BUF_OE   = 1;
  localparam int IO_BUF_POL  = 0;
  localparam int IO_THR_OE   = 3;
  localparam int IO_THR_POL  = 2;
  localparam logic [6:0] THRESHOLD_RESET = 7'h40;

  // power and irq fields
  localparam int PWR_PD      = 0;
  localparam int PWR_PENDING = 1;
  localparam int IRQ_REG_RDY = 0;
  localparam logic [7:0] POWER_DELAY_RESET = 8'h10;

  // strobe commands
  localparam logic [7:0] CMD_RX_ON  = 8'h01;
  localparam logic [7:0] CMD_TX_ON  = 8'h02;
  localparam logic [7:0] CMD_RF_OFF = 8'h03;

  // identity values, arbitrary
  localparam logic [7:0] REVISION_DEFAULT = 8'h3a;
  localparam logic [7:0] IDENTITY_DEFAULT = 8'h5c;

  // timing
  localparam int CLK_NS         = 10;
  localparam int SYMBOL_NS      = 16000;
  localparam int RX_TO_SYMBOLS  = 12;
  localparam int RX_TO_CYCLES   = SYMBOL_NS * RX_TO_SYMBOLS / CLK_NS;
  localparam int REG_UNIT_CYCLES = 32;

  // live inputs from the radio core
  typedef struct packed {
    logic [7:0] rx_count;
    logic       rx_busy;
    logic       tx_active;
    logic       tx_done;
    logic       rx_end;
    logic       sfd;
    logic       cca;
    logic       filter_pending;
  } rfsr_link_t;

  // controls towards the radio core
  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic rf_off;
    logic abort_rx;
    logic auto_rx;
    logic rx_timeout;
    logic pending_to_mod;
    logic accept_ack;
    logic ana_reg_en;
    logic dig_reg_en;
  } rfsr_ctrl_t;

endpackage

// ### tb/tb_rfsr_regs.sv
// tb_rfsr_regs: self-checking bench for the radio frame status register bank.
// assumes rfsr_pkg and rfsr_regs compiled first; the bench drives apb and radio inputs.
`timescale 1ns/10ps

module tb_rfsr_regs;
  import rfsr_pkg::*;

  localparam int TO_CYC = 20;
  localparam int UNIT   = 2;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  rfsr_link_t        link;
  logic [1:0]        pm_mode;
  rfsr_ctrl_t        ctrl;
  logic [3:0]        dbg_out;
  logic [3:0]        dbg_oe;
  int                n_errors;
  int                compares;
  int                n_cmd [4];
  int                n_abort, n_auto, n_to;
  logic [7:0]        m_thr, m_b, m_c, m_d;

  rfsr_regs #(.RX_TO_CYC(TO_CYC), .REG_UNIT(UNIT)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .pm_mode(pm_mode), .ctrl(ctrl), .dbg_out(dbg_out), .dbg_oe(dbg_oe));

  // free-running 100 mhz clock
  always #5 pclk = ~pclk;

  // tally one-cycle control pulses
  always @(posedge pclk) begin
    if (ctrl.rx_on === 1'b1) n_cmd[1]++;
    if (ctrl.tx_on === 1'b1) n_cmd[2]++;
    if (ctrl.rf_off === 1'b1) n_cmd[3]++;
    if (ctrl.abort_rx === 1'b1) n_abort++;
    if (ctrl.auto_rx === 1'b1) n_auto++;
    if (ctrl.rx_timeout === 1'b1) n_to++;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    if (n >= 50) n_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, {24'h0, d}, r, e);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk({e, r}, {9'h0, 16'h0, exp});
  endtask

  // model of the live status byte and debug pins
  function automatic logic [7:0] exp_status();
    return {3'b0, link.tx_active, link.rx_count != 8'h0, link.rx_count > m_thr, link.sfd,
            link.cca};
  endfunction

  function automatic logic [7:0] exp_dbg();
    logic [3:0] s;
    logic [3:0] oe;
    logic [7:0] v;
    v  = exp_status();
    s  = {v[0], v[1], v[2], v[3]} ^ {m_b[5], m_c[5], m_d[2], m_d[0]}; // pins reverse status order
    oe = {m_b[6] && m_b[4:0] == 5'h0, m_c[6] && m_c[4:0] == 5'h0, m_d[3], m_d[1]};
    return {oe, s & oe};
  endfunction

  task automatic wrap_up();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  cmd;
    logic        intr;
    int          a0, c0, t0, n;
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; link = '0; pm_mode = 2'd0;
    n_errors = 0; compares = 0; n_abort = 0; n_auto = 0; n_to = 0;
    n_cmd = '{0, 0, 0, 0};
    m_thr = 8'h40; m_b = 8'h0; m_c = 8'h0; m_d = 8'h0;
    void'($urandom(42432));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of threshold, fsm timing, power, delay and irq registers
    rdc(IDX_IO_CONFIG_A, 8'h40);
    rdc(IDX_FSM_TIMING, 8'h21);
    rdc(IDX_RADIO_POWER, 8'h03);
    rdc(IDX_IRQ_FLAGS, 8'h00);
    rdc(IDX_POWER_DELAY, POWER_DELAY_RESET);
    // unmapped place answers with an error and no data
    apb(1'b0, 16'hdf55, 32'h0, r, e);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, 16'hdf55, 32'hff, r, e);
    chk({32'h0, e}, 33'h1);
    // writes to read-only registers are ignored
    foreach (n_cmd[i]) wr(16'(IDX_RX_BYTE_COUNT + 16'(i)), 8'hff);
    foreach (n_cmd[i]) wr(16'(IDX_SILICON_REV + 16'(i)), 8'hff);
    rdc(IDX_RX_BYTE_COUNT, 8'h00);
    rdc(IDX_FSM_TIMING, 8'h2f);
    rdc(IDX_SILICON_REV, REVISION_DEFAULT);
    rdc(IDX_SILICON_ID, IDENTITY_DEFAULT);
    rdc(IDX_LIVE_STATUS, exp_status());
    // random status, threshold boundary and pin routing
    for (int i = 0; i < 24; i++) begin
      m_thr = (i < 4) ? 8'h40 : 8'($urandom_range(0, 127));
      m_b = 8'($urandom_range(0, 127)) & (i[0] ? 8'h60 : 8'h7f);
      m_c = 8'($urandom_range(0, 127)) & (i[1] ? 8'h60 : 8'h7f);
      m_d = 8'($urandom_range(0, 15));
      wr(IDX_IO_CONFIG_A, m_thr);
      wr(IDX_IO_CONFIG_B, m_b);
      wr(IDX_IO_CONFIG_C, m_c);
      wr(IDX_IO_CONFIG_D, m_d);
      link.rx_count <= (i < 3) ? 8'(63 + i) : (i == 3 ? 8'h0 : 8'($urandom_range(0, 255)));
      link.tx_active <= 1'($urandom);
      link.sfd <= 1'($urandom);
      link.cca <= 1'($urandom);
      repeat (3) @(posedge pclk);
      rdc(IDX_LIVE_STATUS, exp_status());
      rdc(IDX_RX_BYTE_COUNT, link.rx_count);
      rdc(IDX_IO_CONFIG_A, m_thr);
      rdc(IDX_IO_CONFIG_B, m_b);
      chk({25'h0, dbg_oe, dbg_out}, {25'h0, exp_dbg()});
    end
    // strobes against busy reception with both abort settings
    for (int i = 0; i < 12; i++) begin
      wr(IDX_FSM_TIMING, {2'b0, i[0], 5'h01});
      link.rx_busy <= i[1];
      cmd = 8'(1 + i / 4);
      intr = i[1] && (cmd != CMD_RX_ON || i[0]);
      a0 = n_abort;
      c0 = n_cmd[cmd];
      wr(IDX_STROBE, cmd);
      repeat (3) @(posedge pclk);
      chk(33'(n_abort - a0), {32'h0, intr});
      chk(33'(n_cmd[cmd] - c0), 33'h1);
      rdc(IDX_FSM_TIMING, {2'b0, i[0], intr, 4'h1});
    end
    rdc(IDX_STROBE, 8'h00);
    // auto receive, timeout, pending and acknowledge controls
    for (int k = 0; k < 8; k++) begin
      wr(IDX_FSM_TIMING, {4'h2, k[0], k[2], k[1], k[0]});
      link.filter_pending <= k[0] ^ k[1];
      a0 = n_auto;
      t0 = n_to;
      @(posedge pclk);
      link.tx_done <= 1'b1;
      link.rx_end <= 1'b1;
      @(posedge pclk);
      link.tx_done <= 1'b0;
      link.rx_end <= 1'b0;
      repeat (TO_CYC - 3) @(posedge pclk);
      chk(33'(n_to - t0), 33'h0);
      chk(33'(n_auto - a0), {32'h0, !k[0]});
      chk({31'h0, ctrl.pending_to_mod, ctrl.accept_ack},
          {31'h0, k[1] | (k[0] ^ k[1]), k[0]});
      repeat (8) @(posedge pclk);
      chk(33'(n_to - t0), {32'h0, !k[2]});
    end
    // delayed analog regulator power-on
    wr(IDX_POWER_DELAY, 8'h03);
    wr(IDX_RADIO_POWER, 8'h01);
    repeat (2) @(posedge pclk);
    chk({32'h0, ctrl.ana_reg_en}, 33'h0);
    rdc(IDX_RADIO_POWER, 8'h03);
    wr(IDX_RADIO_POWER, 8'h00);
    n = 0;
    while (ctrl.ana_reg_en !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk({32'h0, n >= 3 * UNIT + 1 && n <= 3 * UNIT + 3}, 33'h1);
    rdc(IDX_RADIO_POWER, 8'h00);
    rdc(IDX_IRQ_FLAGS, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h01);
    rdc(IDX_IRQ_FLAGS, 8'h00);
    // deep power modes drop the digital regulator and keep state
    for (int m = 0; m < 4; m++) begin
      pm_mode <= 2'(m);
      repeat (3) @(posedge pclk);
      chk({32'h0, ctrl.dig_reg_en}, {32'h0, m < 2});
      rdc(IDX_IO_CONFIG_A, m_thr);
    end
    pm_mode <= 2'd0;
    wrap_up();
  end

endmodule
